// ===== logic/tcu_defines.svh
// Constants of the timer capture/compare unit: register indices, bit
// positions, reset values and timing counts.
// Assumes a word-addressed bus: byte address is four times the index.
//
// Overview of operation
// (RQ1) Source select bit picks pin or comparator
// (RQ2) Active edge copies counter, sets capture flag
// (RQ3) Edge select: 1 rising, 0 falling; kept
// (RQ4) Captured value is prior count plus one
// (RQ5) High byte read blocks capture until low
// (RQ6) Status read then low read clears capture
// (RQ7) Capture registers survive reset, hold latest
// (RQ8) Compare checked once per counter increment
// (RQ9) Match drives pin to level, sets flag
// (RQ10) Level latched on match regardless of flag
// (RQ11) Compare registers read/write, kept over reset
// (RQ12) Compare high write inhibits until low write
// (RQ13) Status read then low access clears compare
// (RQ14) Software masks, writes high, status, low
// (RQ15) Enable bits gate each flag to interrupt
// (RQ16) Reset clears control except edge select
// (RQ17) Status writes ignored; reset keeps flags
// (RQ18) Wrap sets overflow; status, low read clears
// (RQ19) Comparator trigger needs source, edge set; with edge select clear the code captures on a falling comparator edge
// (RQ20) Timer runs and interrupts in wait, halt
// (RQ21) Stop freezes counter; reset exit presets
// (RQ22) Stop edge arms; shows on wake only
// (RQ23) Counter advances every fourth bus clock
// (RQ24) Set wins over a same-cycle clear
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

`define TCU_IX_CTRL    6'h12
`define TCU_IX_STAT    6'h13
`define TCU_IX_CAPH    6'h14
`define TCU_IX_CAPL    6'h15
`define TCU_IX_CMPH    6'h16
`define TCU_IX_CMPL    6'h17
`define TCU_IX_CNTH    6'h18
`define TCU_IX_CNTL    6'h19
`define TCU_IX_ANA     6'h1d

`define TCU_B_CAP_IE   7
`define TCU_B_CMP_IE   6
`define TCU_B_OVF_IE   5
`define TCU_B_EDGE     1
`define TCU_B_LEVEL    0
`define TCU_B_CAP_F    7
`define TCU_B_CMP_F    6
`define TCU_B_OVF_F    5
`define TCU_B_SRC      0

`define TCU_CNT_PRESET 16'hfffc
`define TCU_CNT_TOP    16'hffff
`define TCU_PRE_LAST   2'h3

`endif

// ===== logic/tcu_pkg.sv
// Types shared by the timer capture/compare unit.
// Assumes nothing of its surroundings.
package tcu_pkg;
    typedef logic [15:0] tcu_count_t;
    typedef logic [7:0]  tcu_byte_t;
    typedef logic [5:0]  tcu_index_t;
endpackage : tcu_pkg

// ===== logic/tcu_top.sv
// Timer capture/compare unit: prescaler, 16-bit counter, capture,
// compare, flags and an AHB-Lite register slave.
// Assumes pins synchronous to sys_clk and a single bus master.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "tcu_defines.svh"

module tcu_top (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        power_on_reset,
    input  wire logic        stop_mode,
    input  wire logic        capture_input_pin,
    input  wire logic        comparator_two_flag,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             compare_output_pin,
    output logic             timer_irq
);
    tcu_pkg::tcu_count_t cnt_r, cap_r, arm_val_r, cmp_r, cnt_inc;
    tcu_pkg::tcu_byte_t  lsb_lat_r, rd_mux, wdat;
    tcu_pkg::tcu_index_t idx, wr_idx_r;
    logic [1:0] pre_r;
    logic src_d_r, src_vld_r, stop_d_r, armed_r, cap_hold_r;
    logic cap_f_r, cmp_f_r, ovf_f_r;
    logic arm_cap_r, arm_cmp_r, arm_ovf_r;
    logic cap_ie_r, cmp_ie_r, ovf_ie_r, edge_r, level_r, src_sel_r;
    logic cmp_inh_r, lat_r, wr_pend_r;
    logic rst_any, addr_ok, rd_go, tick, cmp_match, ovf_evt;
    logic src, edge_seen, cap_evt, wake, wake_arm, cap_load;
    logic rd_stat, rd_caph, rd_capl, rd_cnth, rd_cntl, acc_cmpl;
    logic wr_ctrl, wr_cmph, wr_cmpl, wr_ana;
    logic clr_cap, clr_cmp, clr_ovf;

    // Compare registers, capture data, flags and edge select survive
    // the ordinary reset; only power-on gives them a defined value.
    assign rst_any = reset | power_on_reset;

    // Bus decode; side effects of reads act at the address phase
    assign addr_ok  = hsel && htrans[1] && hready;
    assign rd_go    = addr_ok && !hwrite;
    assign idx      = haddr[7:2];
    assign rd_stat  = rd_go && (idx == `TCU_IX_STAT);
    assign rd_caph  = rd_go && (idx == `TCU_IX_CAPH);
    assign rd_capl  = rd_go && (idx == `TCU_IX_CAPL);
    assign rd_cnth  = rd_go && (idx == `TCU_IX_CNTH);
    assign rd_cntl  = rd_go && (idx == `TCU_IX_CNTL);
    assign acc_cmpl = addr_ok && (idx == `TCU_IX_CMPL);
    assign wdat     = hwdata[7:0];
    assign wr_ctrl  = wr_pend_r && (wr_idx_r == `TCU_IX_CTRL);
    assign wr_cmph  = wr_pend_r && (wr_idx_r == `TCU_IX_CMPH);
    assign wr_cmpl  = wr_pend_r && (wr_idx_r == `TCU_IX_CMPL);
    assign wr_ana   = wr_pend_r && (wr_idx_r == `TCU_IX_ANA);

    assign rd_mux =
        (idx == `TCU_IX_CTRL) ? {cap_ie_r, cmp_ie_r, ovf_ie_r, 3'h0,
                                 edge_r, level_r} :
        (idx == `TCU_IX_STAT) ? {cap_f_r, cmp_f_r, ovf_f_r, 5'h00} :
        (idx == `TCU_IX_CAPH) ? cap_r[15:8] :
        (idx == `TCU_IX_CAPL) ? cap_r[7:0] :
        (idx == `TCU_IX_CMPH) ? cmp_r[15:8] :
        (idx == `TCU_IX_CMPL) ? cmp_r[7:0] :
        (idx == `TCU_IX_CNTH) ? cnt_r[15:8] :
        (idx == `TCU_IX_CNTL) ? (lat_r ? lsb_lat_r : cnt_r[7:0]) :
        (idx == `TCU_IX_ANA)  ? {7'h00, src_sel_r} : 8'h00;

    // Counter and prescaler; nothing moves while stopped
    assign tick    = (pre_r == `TCU_PRE_LAST) && !stop_mode; // RQ23
    assign cnt_inc = cnt_r + 16'h0001;
    assign ovf_evt = tick && (cnt_r == `TCU_CNT_TOP); // RQ18
    assign cmp_match = tick && !cmp_inh_r && (cnt_r == cmp_r); // RQ8 RQ12

    // Capture path
    assign src = src_sel_r ? comparator_two_flag : capture_input_pin; // RQ1
    assign edge_seen = src_vld_r && (edge_r ? (src && !src_d_r)
                                            : (!src && src_d_r)); // RQ3
    assign cap_evt  = edge_seen && !cap_hold_r; // RQ5
    assign wake     = stop_d_r && !stop_mode;
    assign wake_arm = wake && armed_r && !cap_hold_r; // RQ22
    assign cap_load = (cap_evt && !stop_mode) || wake_arm;

    // Flag clears need an arming status read first
    assign clr_cap = rd_capl && arm_cap_r; // RQ6
    assign clr_cmp = acc_cmpl && arm_cmp_r; // RQ13
    assign clr_ovf = rd_cntl && arm_ovf_r; // RQ18

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            pre_r <= 2'h0;
            cnt_r <= `TCU_CNT_PRESET; // RQ21
        end else if (!stop_mode) begin // RQ21
            pre_r <= pre_r + 2'h1;
            if (tick) begin
                cnt_r <= cnt_inc; // RQ23
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        src_d_r  <= src;
        stop_d_r <= stop_mode;
        if (rst_any) begin
            src_vld_r <= 1'b0;
        end else begin
            src_vld_r <= 1'b1;
        end
    end

    // Edge during stop is parked, then shown at wake. A reset exit
    // drops it, so no flag or data appears.
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            armed_r <= 1'b0; // RQ22
        end else if (cap_evt && stop_mode && !armed_r) begin
            armed_r   <= 1'b1; // RQ22
            arm_val_r <= cnt_inc;
        end else if (wake) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (power_on_reset) begin
            cap_r <= 16'h0000;
        end else if (cap_evt && !stop_mode) begin
            cap_r <= cnt_inc; // RQ2 RQ4 RQ7
        end else if (wake_arm) begin
            cap_r <= arm_val_r; // RQ22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            cap_hold_r <= 1'b0;
        end else if (rd_caph) begin
            cap_hold_r <= 1'b1; // RQ5
        end else if (rd_capl) begin
            cap_hold_r <= 1'b0;
        end
    end

    // Flags: an event in the clearing cycle keeps the flag set
    always_ff @(posedge sys_clk) begin
        if (power_on_reset) begin
            cap_f_r <= 1'b0;
            cmp_f_r <= 1'b0;
            ovf_f_r <= 1'b0;
        end else begin // RQ17
            cap_f_r <= cap_load || (cap_f_r && !clr_cap); // RQ24
            cmp_f_r <= cmp_match || (cmp_f_r && !clr_cmp); // RQ9 RQ24
            ovf_f_r <= ovf_evt || (ovf_f_r && !clr_ovf); // RQ24
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            arm_cap_r <= 1'b0;
            arm_cmp_r <= 1'b0;
            arm_ovf_r <= 1'b0;
        end else begin
            arm_cap_r <= (rd_stat && cap_f_r) || (arm_cap_r && !rd_capl);
            arm_cmp_r <= (rd_stat && cmp_f_r) || (arm_cmp_r && !acc_cmpl);
            arm_ovf_r <= (rd_stat && ovf_f_r) || (arm_ovf_r && !rd_cntl);
        end
    end

    // Control bits; edge select only takes power-on
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            cap_ie_r  <= 1'b0; // RQ16
            cmp_ie_r  <= 1'b0;
            ovf_ie_r  <= 1'b0;
            level_r   <= 1'b0;
            src_sel_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cap_ie_r <= wdat[`TCU_B_CAP_IE];
                cmp_ie_r <= wdat[`TCU_B_CMP_IE];
                ovf_ie_r <= wdat[`TCU_B_OVF_IE];
                level_r  <= wdat[`TCU_B_LEVEL];
            end
            if (wr_ana) begin
                src_sel_r <= wdat[`TCU_B_SRC];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (power_on_reset) begin
            edge_r <= 1'b0;
        end else if (wr_ctrl) begin
            edge_r <= wdat[`TCU_B_EDGE]; // RQ3 RQ16
        end
    end

    // Compare value: kept across ordinary reset
    always_ff @(posedge sys_clk) begin
        if (power_on_reset) begin
            cmp_r <= 16'h0000;
        end else begin
            if (wr_cmph) begin
                cmp_r[15:8] <= wdat; // RQ11
            end
            if (wr_cmpl) begin
                cmp_r[7:0] <= wdat; // RQ11
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            cmp_inh_r <= 1'b0;
        end else if (wr_cmph) begin
            cmp_inh_r <= 1'b1; // RQ12
        end else if (wr_cmpl) begin
            cmp_inh_r <= 1'b0;
        end
    end

    // Counter low byte freezes after a high read until read itself
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            lat_r     <= 1'b0;
            lsb_lat_r <= 8'h00;
        end else if (rd_cnth) begin
            lat_r <= 1'b1;
            if (!lat_r) begin
                lsb_lat_r <= cnt_r[7:0];
            end
        end else if (rd_cntl) begin
            lat_r <= 1'b0;
        end
    end

    // Level is latched on every match, flag or not
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            compare_output_pin <= 1'b0;
        end else if (cmp_match) begin
            compare_output_pin <= level_r; // RQ9 RQ10
        end
    end

    // No gating by low-power state: wait and halt wake on this
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= (cap_f_r && cap_ie_r) || (cmp_f_r && cmp_ie_r)
                      || (ovf_f_r && ovf_ie_r); // RQ15 RQ20
        end
    end

    // Zero-wait slave; reads answer in the data phase
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 6'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r  <= idx;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_go) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    default clocking dflt_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst_any);

    count_tick_a: assert property ( // RQ23
        tick |=> cnt_r == $past(cnt_inc))
        else $error("counter did not advance on tick");

    stop_freeze_a: assert property ( // RQ21
        stop_mode && $past(stop_mode) |-> $stable(cnt_r))
        else $error("counter moved during stop");

    tick_spacing_a: assert property ( // RQ23
        tick |=> !tick [*3])
        else $error("ticks closer than four cycles");

    cap_value_a: assert property ( // RQ4
        cap_evt && !stop_mode && !wake_arm
        |=> cap_r == $past(cnt_r) + 16'h0001 && cap_f_r)
        else $error("capture value or flag wrong");

    cap_hold_a: assert property ( // RQ5
        cap_hold_r && !rd_capl |=> $stable(cap_r))
        else $error("capture changed while held");

    cmp_pin_a: assert property ( // RQ9
        cmp_match |=> compare_output_pin == $past(level_r) && cmp_f_r)
        else $error("compare pin or flag wrong");

    cmp_inhibit_a: assert property ( // RQ12
        cmp_inh_r |=> $stable(compare_output_pin))
        else $error("compare pin moved while inhibited");

    ovf_flag_a: assert property ( // RQ18
        ovf_evt |=> ovf_f_r && cnt_r == 16'h0000)
        else $error("overflow not flagged at wrap");

    flag_keep_a: assert property ( // RQ6
        cap_f_r && !(rd_capl && arm_cap_r) |=> cap_f_r)
        else $error("capture flag lost without clear");

    irq_a: assert property ( // RQ15
        (cmp_f_r && cmp_ie_r) |=> timer_irq)
        else $error("enabled flag raised no interrupt");

endmodule : tcu_top

// ===== dv/tcu_pins.sv
// Far-side model: capture pin and comparator flag sources.
// Assumes levels requested by the bench; applied lag plus one cycles later.
`timescale 1ns/1ps
module tcu_pins (
    input  wire logic       sys_clk,
    input  wire logic       cap_req,
    input  wire logic       cmp_req,
    input  wire logic [1:0] lag,
    output logic            capture_input_pin,
    output logic            comparator_two_flag
);
    logic [3:0] cap_r = 4'h0;
    logic [3:0] cmp_r = 4'h0;
    // Levels move only after an edge: the pins are synchronous inputs
    always @(posedge sys_clk) begin
        cap_r <= {cap_r[2:0], cap_req};
        cmp_r <= {cmp_r[2:0], cmp_req};
    end
    assign capture_input_pin   = cap_r[lag];
    assign comparator_two_flag = cmp_r[lag];
endmodule : tcu_pins

// ===== dv/tcu_top_tb_top.sv
// Self-checking bench for the timer capture/compare unit.
// Assumes hready is fed back from hreadyout; one bus master.
`timescale 1ns/1ps
`include "tcu_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tcu_top_tb_top;
    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic        por       = 1'b1;
    logic        stop_mode = 1'b0;
    logic        cap_req   = 1'b0;
    logic        cmp_req   = 1'b0;
    logic [1:0]  lag       = 2'h0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] seed      = 32'h1e99;
    logic [31:0] hrdata, got, exp_v;
    logic        hreadyout, hresp, cmp_pin, timer_irq, cap_pin, cmp_f;
    logic [15:0] cnt, tgt, cap;
    logic [31:0] q[$];
    int          err_count = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    event        rd_ev;

    tcu_top i_dut (.sys_clk(sys_clk), .reset(reset),
        .power_on_reset(por), .stop_mode(stop_mode),
        .capture_input_pin(cap_pin), .comparator_two_flag(cmp_f),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .compare_output_pin(cmp_pin), .timer_irq(timer_irq));
    tcu_pins i_pins (.sys_clk(sys_clk), .cap_req(cap_req),
        .cmp_req(cmp_req), .lag(lag), .capture_input_pin(cap_pin),
        .comparator_two_flag(cmp_f));

    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt

    task automatic bus(input logic [5:0] ix, input logic wr,
                       input logic [7:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ix, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        logic [31:0] x;
        bus(ix, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [5:0] ix, input logic [7:0] e);
        q.push_back({24'h0, e});
        bus(ix, 1'b0, 8'h0, got);
        ->rd_ev;
    endtask : rd

    // Hi read latches lo, so the pair is one coherent count
    task automatic cnt_rd();
        logic [31:0] h, l;
        bus(`TCU_IX_CNTH, 1'b0, 8'h0, h);
        bus(`TCU_IX_CNTL, 1'b0, 8'h0, l);
        cnt = {h[7:0], l[7:0]};
    endtask : cnt_rd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    always @(rd_ev) begin
        exp_v = q.pop_front();
        `CHK("hrdata", exp_v, got)
        `CHK("hresp", 1'b0, hresp)
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] v;
        wt(8);
        reset <= 1'b0;
        por   <= 1'b0;
        rd(`TCU_IX_CTRL, 8'h00);
        rd(`TCU_IX_CNTH, 8'hff);
        rd(`TCU_IX_CNTL, 8'hfc);
        wr(`TCU_IX_CMPH, 8'h80);
        wr(`TCU_IX_CMPL, 8'h00);
        wr(`TCU_IX_CTRL, 8'h20);
        v = rnd();
        wr(`TCU_IX_STAT, v[7:0]);
        wr(6'h00, v[15:8]);
        rd(6'h00, 8'h00);
        wt(24);
        `CHK("irq", 1'b1, timer_irq)
        rd(`TCU_IX_STAT, 8'h20);
        cnt_rd();
        rd(`TCU_IX_STAT, 8'h00);
        `CHK("irq", 1'b0, timer_irq)
        $display("test overflow done");
        // Low first, then high: match must stay inhibited
        wr(`TCU_IX_CTRL, 8'h01);
        cnt_rd();
        tgt = cnt + 16'd12;
        wr(`TCU_IX_CMPL, tgt[7:0]);
        wr(`TCU_IX_CMPH, tgt[15:8]);
        wt(96);
        `CHK("pin", 1'b0, cmp_pin)
        cnt_rd();
        v = rnd();
        tgt = cnt + 16'd12 + {13'h0, v[2:0]};
        wr(`TCU_IX_CMPH, tgt[15:8]);
        rd(`TCU_IX_STAT, 8'h00);
        wr(`TCU_IX_CMPL, tgt[7:0]);
        wt(96);
        `CHK("pin", 1'b1, cmp_pin)
        `CHK("irq", 1'b0, timer_irq)
        wr(`TCU_IX_CTRL, 8'h40);
        cnt_rd();
        tgt = cnt + 16'd12;
        wr(`TCU_IX_CMPH, tgt[15:8]);
        wr(`TCU_IX_CMPL, tgt[7:0]);
        wt(96);
        `CHK("pin", 1'b0, cmp_pin)
        `CHK("irq", 1'b1, timer_irq)
        rd(`TCU_IX_STAT, 8'h40);
        $display("test compare done");
        wr(`TCU_IX_CTRL, 8'h82);
        stop_mode <= 1'b1;
        wt(4);
        cnt_rd();
        wt(8);
        rd(`TCU_IX_CNTH, cnt[15:8]);
        rd(`TCU_IX_CNTL, cnt[7:0]);
        cap_req <= 1'b1;
        wt(8);
        rd(`TCU_IX_STAT, 8'h40);
        stop_mode <= 1'b0;
        wt(4);
        `CHK("irq", 1'b1, timer_irq)
        cap = cnt + 16'd1;
        rd(`TCU_IX_STAT, 8'hc0);
        rd(`TCU_IX_CAPH, cap[15:8]);
        cap_req <= 1'b0;
        wt(8);
        cap_req <= 1'b1;
        wt(8);
        rd(`TCU_IX_CAPL, cap[7:0]);
        rd(`TCU_IX_STAT, 8'h40);
        $display("test capture done");
        wr(`TCU_IX_ANA, 8'h01);
        cap_req <= 1'b0;
        wt(8);
        cap_req <= 1'b1;
        wt(8);
        rd(`TCU_IX_STAT, 8'h40);
        v = rnd();
        lag <= v[1:0];
        cmp_req <= 1'b1;
        wt(8);
        rd(`TCU_IX_STAT, 8'hc0);
        cnt_rd();
        bus(`TCU_IX_CAPL, 1'b0, 8'h0, v);
        wr(`TCU_IX_ANA, 8'h00);
        wr(`TCU_IX_CTRL, 8'h80);
        cap_req <= 1'b0;
        wt(8);
        rd(`TCU_IX_STAT, 8'hc0);
        bus(`TCU_IX_CAPH, 1'b0, 8'h0, v);
        cap[15:8] = v[7:0];
        bus(`TCU_IX_CAPL, 1'b0, 8'h0, v);
        cap[7:0] = v[7:0];
        rd(`TCU_IX_STAT, 8'h40);
        $display("test source done");
        // Parked edge must vanish when stop ends through reset
        wr(`TCU_IX_CTRL, 8'h02);
        stop_mode <= 1'b1;
        wt(4);
        cap_req <= 1'b1;
        wt(8);
        reset <= 1'b1;
        wt(2);
        reset     <= 1'b0;
        stop_mode <= 1'b0;
        rd(`TCU_IX_STAT, 8'h40);
        rd(`TCU_IX_CTRL, 8'h02);
        rd(`TCU_IX_CNTH, 8'hff);
        rd(`TCU_IX_CMPL, tgt[7:0]);
        rd(`TCU_IX_STAT, 8'h00);
        rd(`TCU_IX_CMPH, tgt[15:8]);
        rd(`TCU_IX_CAPH, cap[15:8]);
        rd(`TCU_IX_CAPL, cap[7:0]);
        $display("test reset done");
        finish_test();
    end
endmodule : tcu_top_tb_top
